// file: spj_cfg.svh
// Offsets, field positions, reset values and codes of the speed preset and jog select block
`ifndef SPJ_CFG_SVH
`define SPJ_CFG_SVH
`define SPJ_FW 16
`define SPJ_NPRESET 15
`define SPJ_NTERM 5
`define SPJ_ADR_PRESET_LAST 8'h38
`define SPJ_ADR_JOG_FREQ 8'h3c
`define SPJ_ADR_JOG_RAMP 8'h40
`define SPJ_ADR_REF_FREQ 8'h44
`define SPJ_ADR_BASE_FREQ 8'h48
`define SPJ_ADR_PATTERN 8'h4c
`define SPJ_ADR_START_FREQ 8'h50
`define SPJ_ADR_REMOTE 8'h54
`define SPJ_ADR_OPMODE 8'h58
`define SPJ_ADR_TERM_FN 8'h5c
`define SPJ_ADR_CTRL 8'h60
`define SPJ_ADR_STATUS 8'h64
`define SPJ_RST_HIGH 16'h0258
`define SPJ_RST_MID 16'h012c
`define SPJ_RST_LOW 16'h0064
`define SPJ_UNSET 16'h270f
`define SPJ_RST_JOG_FREQ 16'h0032
`define SPJ_RST_JOG_RAMP 16'h0005
`define SPJ_RST_REF_FREQ 16'h0258
`define SPJ_RST_BASE_FREQ 16'h0258
`define SPJ_RST_START_FREQ 16'h0005
`define SPJ_RST_PATTERN 2'h0
`define SPJ_RST_REMOTE 2'h0
`define SPJ_RST_OPMODE 4'h0
`define SPJ_RST_TERM_FN 20'h58210
`define SPJ_FN_LOW 4'h0
`define SPJ_FN_MID 4'h1
`define SPJ_FN_HIGH 4'h2
`define SPJ_FN_SECOND 4'h3
`define SPJ_FN_JOG 4'h5
`define SPJ_FN_EXTEND 4'h8
`define SPJ_OPS_COMB_A 4'h3
`define SPJ_OPS_COMB_B 4'h4
`define SPJ_PAT_S 2'h1
`define SPJ_REMOTE_OFF 2'h0
`define SPJ_CTRL_PANEL_JOG 0
`define SPJ_ST_SRC_LSB 16
`define SPJ_ST_JOG 19
`define SPJ_ST_FWD 20
`define SPJ_ST_REV 21
`define SPJ_ST_LOW_JOG 22
`endif

// file: spj_pkg.sv
// Types shared by the speed preset and jog select block
package spj_pkg;
    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_JOG = 3'h1,
        SRC_MULTI = 3'h3,
        SRC_CURRENT = 3'h2,
        SRC_VOLTAGE = 3'h6
    } spj_src_e;
    typedef enum logic [1:0] {
        MODE_EXTERNAL = 2'h0,
        MODE_PANEL = 2'h1,
        MODE_NET = 2'h2
    } spj_mode_e;
    typedef enum logic [1:0] {
        RAMP_NORMAL = 2'h0,
        RAMP_SECOND = 2'h1,
        RAMP_JOG = 2'h3
    } spj_ramp_e;
    typedef struct packed {
        logic low;
        logic mid;
        logic high;
        logic second;
        logic jog;
        logic extend;
    } spj_fn_s;
endpackage

// file: spj_term_map.sv
// Maps the programmable input terminals onto speed, jog and second-function signals
`include "spj_cfg.svh"
module spj_term_map (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] term_in,
    input wire logic [19:0] fn_cfg,
    output spj_pkg::spj_fn_s fn_ff
);
    spj_pkg::spj_fn_s hit [`SPJ_NTERM];
    spj_pkg::spj_fn_s nxt_fn;

    genvar t;
    generate
        for (t = 0; t < `SPJ_NTERM; t++) begin : g_term
            logic [3:0] code;
            assign code = fn_cfg[4*t +: 4];
            assign hit[t].low = term_in[t] && (code == `SPJ_FN_LOW);
            assign hit[t].mid = term_in[t] && (code == `SPJ_FN_MID);
            assign hit[t].high = term_in[t] && (code == `SPJ_FN_HIGH);
            assign hit[t].second = term_in[t] && (code == `SPJ_FN_SECOND);
            assign hit[t].jog = term_in[t] && (code == `SPJ_FN_JOG);
            assign hit[t].extend = term_in[t] && (code == `SPJ_FN_EXTEND);
        end
    endgenerate

    always_comb begin
        nxt_fn = '0;
        for (int i = 0; i < `SPJ_NTERM; i++) begin
            nxt_fn = nxt_fn | hit[i];
        end
    end

    // Sampled terminal functions
    always_ff @(posedge clk) begin
        if (rst) begin
            fn_ff <= '0;
        end else begin
            fn_ff <= nxt_fn;
        end
    end
endmodule

// file: spj_speed_select.sv
// Speed preset and jog select: picks the running frequency command of the drive
// Operation
// - High, middle or low select alone runs at its own preset frequency.
// - Several of high, middle, low together: presets four to seven; the lowest select wins while that preset is unset.
// - Terminal function codes 0, 1, 2 map low, middle, high select.
// - Extension alone or with selects chooses presets eight to fifteen, unset by default.
// - Terminal function code 8 maps the speed extension select.
// - Speed eight unset and only extension active runs the low preset.
// - Source order: jog, presets, current input, voltage input.
// - Presets act only in external mode or mode settings 3 or 4.
// - Preset writes are taken in panel or external mode.
// - Remote function nonzero disables presets; selects become remote controls.
// - Jog frequency 0 to 400 Hz, default 5 Hz, used while jogging.
// - One jog ramp time, default 0.5 s, against the reference frequency.
// - External jog runs while a start input is held, stops on release.
// - Terminal function code 5 maps the jog select.
// - Panel jog runs only while the run key is held, or a unit forward/reverse key in mode setting 4.
// - Jog works in external and in panel mode.
// - S-shaped ramp pattern measures jog ramp against the base frequency.
// - While jogging the second-function select does not pick the ramp.
// - Mode setting 4: run key or unit forward/reverse keys start jog.
// - Mode setting 3 disables jog entirely.
`include "spj_cfg.svh"
module spj_speed_select (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [4:0] TERM_IN,
    input wire logic FORWARD_START,
    input wire logic REVERSE_START,
    input wire logic PANEL_RUN_KEY,
    input wire logic UNIT_FWD_KEY,
    input wire logic UNIT_REV_KEY,
    input wire logic [1:0] OPER_MODE,
    input wire logic CURRENT_REF_EN,
    input wire logic [15:0] CURRENT_REF,
    input wire logic [15:0] VOLTAGE_REF,
    output logic [15:0] FREQ_CMD,
    output logic [2:0] FREQ_SRC,
    output logic RUN_FWD,
    output logic RUN_REV,
    output logic JOG_ACTIVE,
    output logic [1:0] RAMP_SEL,
    output logic [15:0] JOG_RAMP_TIME,
    output logic [15:0] RAMP_REF_FREQ,
    output logic REMOTE_UP,
    output logic REMOTE_DOWN,
    output logic REMOTE_CLEAR
);
    logic [15:0] preset_ff [`SPJ_NPRESET];
    logic [15:0] jog_freq_ff, jog_ramp_ff, ref_freq_ff, base_freq_ff, start_freq_ff;
    logic [1:0] pattern_ff, remote_ff;
    logic [3:0] opmode_ff;
    logic [19:0] term_fn_ff;
    logic ctrl_panel_jog_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    spj_pkg::spj_fn_s fn;
    logic fwd_ff, rev_ff, key_ff, ufwd_ff, urev_ff, cur_en_ff;
    logic [1:0] mode_ff;
    logic [15:0] cur_ref_ff, volt_ref_ff;
    logic wr_en, rd_en, preset_wr_ok;
    logic multi_ok, jog_ok, jog_terminal, jog_panel, jog_act;
    logic [3:0] speed, nxt_speed;
    logic [15:0] nxt_freq;
    spj_pkg::spj_src_e nxt_src;
    spj_pkg::spj_ramp_e nxt_ramp;
    logic nxt_fwd, nxt_rev;
    logic [31:0] nxt_rdata;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [3:0] decode(input spj_pkg::spj_fn_s f);
        logic [3:0] s;
        case ({f.extend, f.high, f.mid, f.low})
            4'h1: s = 4'h3;
            4'h2: s = 4'h2;
            4'h3: s = 4'h4;
            4'h4: s = 4'h1;
            4'h5: s = 4'h5;
            4'h6: s = 4'h6;
            4'h7: s = 4'h7;
            4'h8: s = 4'h8;
            4'h9: s = 4'h9;
            4'ha: s = 4'ha;
            4'hb: s = 4'hb;
            4'hc: s = 4'hc;
            4'hd: s = 4'hd;
            4'he: s = 4'he;
            4'hf: s = 4'hf;
            default: s = 4'h0;
        endcase
        return s;
    endfunction

    spj_term_map u_map (
        .clk(REF_CLK),
        .rst(RST),
        .term_in(TERM_IN),
        .fn_cfg(term_fn_ff),
        .fn_ff(fn)
    );

    // Input sampling
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            fwd_ff <= 1'b0;
            rev_ff <= 1'b0;
            key_ff <= 1'b0;
            ufwd_ff <= 1'b0;
            urev_ff <= 1'b0;
            cur_en_ff <= 1'b0;
            mode_ff <= 2'h0;
            cur_ref_ff <= 16'h0000;
            volt_ref_ff <= 16'h0000;
        end else begin
            fwd_ff <= FORWARD_START;
            rev_ff <= REVERSE_START;
            key_ff <= PANEL_RUN_KEY;
            ufwd_ff <= UNIT_FWD_KEY;
            urev_ff <= UNIT_REV_KEY;
            cur_en_ff <= CURRENT_REF_EN;
            mode_ff <= OPER_MODE;
            cur_ref_ff <= CURRENT_REF;
            volt_ref_ff <= VOLTAGE_REF;
        end
    end

    // Bus decode
    assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_ff;
    assign rd_en = WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_ff;
    assign preset_wr_ok = (mode_ff == spj_pkg::MODE_EXTERNAL)
        || (mode_ff == spj_pkg::MODE_PANEL);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= WB_CYC_I && WB_STB_I && !ack_ff;
        end
    end

    // Preset table
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            for (int i = 0; i < `SPJ_NPRESET; i++) begin
                preset_ff[i] <= `SPJ_UNSET;
            end
            preset_ff[0] <= `SPJ_RST_HIGH;
            preset_ff[1] <= `SPJ_RST_MID;
            preset_ff[2] <= `SPJ_RST_LOW;
        end else if (wr_en && preset_wr_ok && WB_ADR_I <= `SPJ_ADR_PRESET_LAST
                     && WB_ADR_I[1:0] == 2'h0) begin
            preset_ff[WB_ADR_I[5:2]] <= 16'(merge({16'h0000, preset_ff[WB_ADR_I[5:2]]},
                                                  WB_DAT_I, WB_SEL_I));
        end
    end

    // Setting registers
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            jog_freq_ff <= `SPJ_RST_JOG_FREQ;
            jog_ramp_ff <= `SPJ_RST_JOG_RAMP;
            ref_freq_ff <= `SPJ_RST_REF_FREQ;
            base_freq_ff <= `SPJ_RST_BASE_FREQ;
            start_freq_ff <= `SPJ_RST_START_FREQ;
            pattern_ff <= `SPJ_RST_PATTERN;
            remote_ff <= `SPJ_RST_REMOTE;
            opmode_ff <= `SPJ_RST_OPMODE;
            term_fn_ff <= `SPJ_RST_TERM_FN;
            ctrl_panel_jog_ff <= 1'b0;
        end else if (wr_en) begin
            if (WB_ADR_I == `SPJ_ADR_JOG_FREQ) begin
                jog_freq_ff <= 16'(merge({16'h0000, jog_freq_ff}, WB_DAT_I, WB_SEL_I));
            end else if (WB_ADR_I == `SPJ_ADR_JOG_RAMP) begin
                jog_ramp_ff <= 16'(merge({16'h0000, jog_ramp_ff}, WB_DAT_I, WB_SEL_I));
            end else if (WB_ADR_I == `SPJ_ADR_REF_FREQ) begin
                ref_freq_ff <= 16'(merge({16'h0000, ref_freq_ff}, WB_DAT_I, WB_SEL_I));
            end else if (WB_ADR_I == `SPJ_ADR_BASE_FREQ) begin
                base_freq_ff <= 16'(merge({16'h0000, base_freq_ff}, WB_DAT_I, WB_SEL_I));
            end else if (WB_ADR_I == `SPJ_ADR_START_FREQ) begin
                start_freq_ff <= 16'(merge({16'h0000, start_freq_ff}, WB_DAT_I, WB_SEL_I));
            end else if (WB_ADR_I == `SPJ_ADR_PATTERN && WB_SEL_I[0]) begin
                pattern_ff <= WB_DAT_I[1:0];
            end else if (WB_ADR_I == `SPJ_ADR_REMOTE && WB_SEL_I[0]) begin
                remote_ff <= WB_DAT_I[1:0];
            end else if (WB_ADR_I == `SPJ_ADR_OPMODE && WB_SEL_I[0]) begin
                opmode_ff <= WB_DAT_I[3:0];
            end else if (WB_ADR_I == `SPJ_ADR_TERM_FN) begin
                term_fn_ff <= 20'(merge({12'h000, term_fn_ff}, WB_DAT_I, WB_SEL_I));
            end else if (WB_ADR_I == `SPJ_ADR_CTRL && WB_SEL_I[0]) begin
                ctrl_panel_jog_ff <= WB_DAT_I[`SPJ_CTRL_PANEL_JOG];
            end
        end
    end

    // Read mux
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (WB_ADR_I <= `SPJ_ADR_PRESET_LAST && WB_ADR_I[1:0] == 2'h0) begin
            nxt_rdata[15:0] = preset_ff[WB_ADR_I[5:2]];
        end else if (WB_ADR_I == `SPJ_ADR_JOG_FREQ) begin
            nxt_rdata[15:0] = jog_freq_ff;
        end else if (WB_ADR_I == `SPJ_ADR_JOG_RAMP) begin
            nxt_rdata[15:0] = jog_ramp_ff;
        end else if (WB_ADR_I == `SPJ_ADR_REF_FREQ) begin
            nxt_rdata[15:0] = ref_freq_ff;
        end else if (WB_ADR_I == `SPJ_ADR_BASE_FREQ) begin
            nxt_rdata[15:0] = base_freq_ff;
        end else if (WB_ADR_I == `SPJ_ADR_START_FREQ) begin
            nxt_rdata[15:0] = start_freq_ff;
        end else if (WB_ADR_I == `SPJ_ADR_PATTERN) begin
            nxt_rdata[1:0] = pattern_ff;
        end else if (WB_ADR_I == `SPJ_ADR_REMOTE) begin
            nxt_rdata[1:0] = remote_ff;
        end else if (WB_ADR_I == `SPJ_ADR_OPMODE) begin
            nxt_rdata[3:0] = opmode_ff;
        end else if (WB_ADR_I == `SPJ_ADR_TERM_FN) begin
            nxt_rdata[19:0] = term_fn_ff;
        end else if (WB_ADR_I == `SPJ_ADR_CTRL) begin
            nxt_rdata[`SPJ_CTRL_PANEL_JOG] = ctrl_panel_jog_ff;
        end else if (WB_ADR_I == `SPJ_ADR_STATUS) begin
            nxt_rdata[15:0] = FREQ_CMD;
            nxt_rdata[`SPJ_ST_SRC_LSB +: 3] = FREQ_SRC;
            nxt_rdata[`SPJ_ST_JOG] = JOG_ACTIVE;
            nxt_rdata[`SPJ_ST_FWD] = RUN_FWD;
            nxt_rdata[`SPJ_ST_REV] = RUN_REV;
            nxt_rdata[`SPJ_ST_LOW_JOG] = jog_freq_ff < start_freq_ff;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = rdata_ff;

    // Jog qualification
    assign jog_ok = opmode_ff != `SPJ_OPS_COMB_A;
    assign jog_terminal = jog_ok && fn.jog && mode_ff == spj_pkg::MODE_EXTERNAL;
    assign jog_panel = jog_ok && ctrl_panel_jog_ff && mode_ff == spj_pkg::MODE_PANEL;
    assign jog_act = jog_terminal || jog_panel;
    assign multi_ok = remote_ff == `SPJ_REMOTE_OFF
        && (mode_ff == spj_pkg::MODE_EXTERNAL || opmode_ff == `SPJ_OPS_COMB_A
            || opmode_ff == `SPJ_OPS_COMB_B);

    // Preset choice
    always_comb begin
        speed = decode(fn);
        nxt_speed = speed;
        if (speed >= 4'h4 && preset_ff[speed - 4'h1] == `SPJ_UNSET) begin
            if (speed == 4'h8) begin
                nxt_speed = 4'h3;
            end else if (fn.low) begin
                nxt_speed = 4'h3;
            end else if (fn.mid) begin
                nxt_speed = 4'h2;
            end else begin
                nxt_speed = fn.high ? 4'h1 : 4'h0;
            end
        end
    end

    // Source priority
    always_comb begin
        nxt_freq = volt_ref_ff;
        nxt_src = spj_pkg::SRC_VOLTAGE;
        if (jog_act) begin
            nxt_freq = jog_freq_ff;
            nxt_src = spj_pkg::SRC_JOG;
        end else if (multi_ok && nxt_speed != 4'h0) begin
            nxt_freq = preset_ff[nxt_speed - 4'h1];
            nxt_src = spj_pkg::SRC_MULTI;
        end else if (cur_en_ff) begin
            nxt_freq = cur_ref_ff;
            nxt_src = spj_pkg::SRC_CURRENT;
        end
    end

    // Start and direction
    always_comb begin
        nxt_fwd = 1'b0;
        nxt_rev = 1'b0;
        if (jog_panel) begin
            if (opmode_ff == `SPJ_OPS_COMB_B) begin
                nxt_fwd = key_ff || ufwd_ff;
                nxt_rev = urev_ff;
            end else begin
                nxt_fwd = key_ff;
            end
        end else if (mode_ff == spj_pkg::MODE_EXTERNAL) begin
            nxt_fwd = fwd_ff;
            nxt_rev = rev_ff;
        end
        if (nxt_fwd && nxt_rev) begin
            nxt_fwd = 1'b0;
            nxt_rev = 1'b0;
        end
    end

    always_comb begin
        if (jog_act) begin
            nxt_ramp = spj_pkg::RAMP_JOG;
        end else if (fn.second) begin
            nxt_ramp = spj_pkg::RAMP_SECOND;
        end else begin
            nxt_ramp = spj_pkg::RAMP_NORMAL;
        end
    end

    // Registered command
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            FREQ_CMD <= 16'h0000;
            FREQ_SRC <= spj_pkg::SRC_NONE;
            JOG_ACTIVE <= 1'b0;
            RAMP_SEL <= spj_pkg::RAMP_NORMAL;
        end else begin
            FREQ_CMD <= nxt_freq;
            FREQ_SRC <= nxt_src;
            JOG_ACTIVE <= jog_act;
            RAMP_SEL <= nxt_ramp;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RUN_FWD <= 1'b0;
            RUN_REV <= 1'b0;
        end else begin
            RUN_FWD <= nxt_fwd;
            RUN_REV <= nxt_rev;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            JOG_RAMP_TIME <= `SPJ_RST_JOG_RAMP;
            RAMP_REF_FREQ <= `SPJ_RST_REF_FREQ;
        end else begin
            JOG_RAMP_TIME <= jog_ramp_ff;
            RAMP_REF_FREQ <= pattern_ff == `SPJ_PAT_S ? base_freq_ff : ref_freq_ff;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            REMOTE_UP <= 1'b0;
            REMOTE_DOWN <= 1'b0;
            REMOTE_CLEAR <= 1'b0;
        end else begin
            REMOTE_UP <= remote_ff != `SPJ_REMOTE_OFF && !jog_act && fn.high;
            REMOTE_DOWN <= remote_ff != `SPJ_REMOTE_OFF && !jog_act && fn.mid;
            REMOTE_CLEAR <= remote_ff != `SPJ_REMOTE_OFF && !jog_act && fn.low;
        end
    end

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence term_jog_run;
        jog_terminal && fwd_ff && !rev_ff;
    endsequence
    sequence term_start_drop;
        jog_terminal && !fwd_ff && !rev_ff;
    endsequence

    bus_ack_a: assert property (WB_CYC_I && WB_STB_I && !ack_ff |=> ack_ff ##1 !ack_ff)
        else $error("bus ack not a single cycle");
    high_only_a: assert property (
        !jog_act && multi_ok && fn == 6'b001000 |=> FREQ_CMD == $past(preset_ff[0]))
        else $error("high select did not give high preset");
    low_wins_a: assert property (
        !jog_act && multi_ok && fn == 6'b011000 && preset_ff[5] == `SPJ_UNSET
        |=> FREQ_CMD == $past(preset_ff[1]))
        else $error("middle select did not win over high");
    extend_only_a: assert property (
        !jog_act && multi_ok && fn == 6'b000001 && preset_ff[7] == `SPJ_UNSET
        |=> FREQ_SRC == spj_pkg::SRC_MULTI && FREQ_CMD == $past(preset_ff[2]))
        else $error("extension alone did not fall back to low preset");
    jog_first_a: assert property (
        jog_act |=> FREQ_SRC == spj_pkg::SRC_JOG && FREQ_CMD == $past(jog_freq_ff))
        else $error("jog did not take the frequency command");
    multi_mode_a: assert property (
        mode_ff != spj_pkg::MODE_EXTERNAL && opmode_ff != `SPJ_OPS_COMB_A
        && opmode_ff != `SPJ_OPS_COMB_B |=> FREQ_SRC != spj_pkg::SRC_MULTI)
        else $error("presets used outside their modes");
    remote_off_a: assert property (
        remote_ff != `SPJ_REMOTE_OFF |=> FREQ_SRC != spj_pkg::SRC_MULTI)
        else $error("presets used while remote setting active");
    jog_stop_a: assert property (
        term_jog_run ##1 term_start_drop |-> RUN_FWD ##1 !RUN_FWD && !RUN_REV)
        else $error("external jog did not stop on start release");
    panel_key_a: assert property (
        jog_panel && opmode_ff != `SPJ_OPS_COMB_B |=> RUN_FWD == $past(key_ff) && !RUN_REV)
        else $error("panel jog run does not follow the run key");
    ramp_base_a: assert property (
        (pattern_ff == `SPJ_PAT_S) [*2] |-> RAMP_REF_FREQ == $past(base_freq_ff))
        else $error("S ramp not measured against base frequency");
    second_ramp_a: assert property (
        jog_act && fn.second |=> RAMP_SEL == spj_pkg::RAMP_JOG)
        else $error("second ramp chosen during jog");
    mode3_jog_a: assert property (
        opmode_ff == `SPJ_OPS_COMB_A |=> !JOG_ACTIVE)
        else $error("jog active with mode setting 3");
    preset_wr_a: assert property (
        wr_en && !preset_wr_ok && WB_ADR_I == 8'h00 |=> $stable(preset_ff[0]))
        else $error("preset written outside panel or external mode");
endmodule

// file: spj_contacts.sv
// Contact switches and panel keys that drive the block's input pins
module spj_contacts (
    input wire logic clk,
    input wire logic [4:0] term_req,
    input wire logic [4:0] key_req,
    output logic [4:0] term,
    output logic [4:0] keys
);
    // Contacts move just after an edge and then hold their level
    always_ff @(posedge clk) begin
        term <= term_req;
        keys <= key_req;
    end
endmodule

// file: tb_top.sv
// Self-checking bench of the speed preset and jog select block
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd;
    logic [1:0] mode = 2'h0;
    logic cur_en = 1'b0;
    logic [4:0] t_req = 5'h00;
    logic [4:0] k_req = 5'h00;
    wire [4:0] term;
    wire [4:0] keys;
    wire [31:0] dat_o;
    wire ack;
    wire [15:0] freq;
    wire [15:0] jrt;
    wire [15:0] rref;
    wire [2:0] src;
    wire [1:0] ramp;
    wire run_f;
    wire run_r;
    wire jog;
    wire r_up;
    wire r_dn;
    wire r_clr;
    int mismatches = 0;
    int cmp_count = 0;
    always #25 ref_clk = ~ref_clk;
    spj_contacts u_sw (.clk(ref_clk), .term_req(t_req), .key_req(k_req), .term(term),
        .keys(keys));
    spj_speed_select DUT (.REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .TERM_IN(term), .FORWARD_START(keys[0]), .REVERSE_START(keys[1]),
        .PANEL_RUN_KEY(keys[2]), .UNIT_FWD_KEY(keys[3]), .UNIT_REV_KEY(keys[4]),
        .OPER_MODE(mode), .CURRENT_REF_EN(cur_en), .CURRENT_REF(16'h0111),
        .VOLTAGE_REF(16'h0222), .FREQ_CMD(freq), .FREQ_SRC(src), .RUN_FWD(run_f),
        .RUN_REV(run_r), .JOG_ACTIVE(jog), .RAMP_SEL(ramp), .JOG_RAMP_TIME(jrt),
        .RAMP_REF_FREQ(rref), .REMOTE_UP(r_up), .REMOTE_DOWN(r_dn), .REMOTE_CLEAR(r_clr));
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic pins(input logic [4:0] t, input logic [4:0] k);
        @(posedge ref_clk);
        t_req <= t;
        k_req <= k;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic t_regs();
        `CHK("jog_ramp", 16'h0005, jrt)
        `CHK("ramp_ref", 16'h0258, rref)
        wb(1'b0, 8'h3c, 32'h0);
        `CHK("jog_freq_rst", 32'h00000032, rd)
        wb(1'b0, 8'h7c, 32'h0);
        `CHK("unmapped", 32'h0, rd)
    endtask
    task automatic t_presets();
        pins(5'b00001, 5'h00);
        `CHK("low", 16'h0064, freq)
        `CHK("src_multi", 3'h3, src)
        pins(5'b00010, 5'h00);
        `CHK("mid", 16'h012c, freq)
        pins(5'b00100, 5'h00);
        `CHK("high", 16'h0258, freq)
        pins(5'b00110, 5'h00);
        `CHK("high_mid", 16'h012c, freq)
        pins(5'b01000, 5'h00);
        `CHK("ext_only", 16'h0064, freq)
        wb(1'b1, 8'h0c, 32'h00000123);
        pins(5'b00011, 5'h00);
        `CHK("speed4", 16'h0123, freq)
        wb(1'b1, 8'h5c, 32'h00058232);
        pins(5'b00011, 5'h00);
        `CHK("remap_high", 16'h0258, freq)
        `CHK("second_ramp", 2'h1, ramp)
    endtask
    task automatic t_jog();
        // Jog frequency 5 Hz stays above the 0.5 Hz starting frequency
        pins(5'b10011, 5'b00001);
        `CHK("jog_freq", 16'h0032, freq)
        `CHK("jog_src", 3'h1, src)
        `CHK("jog_fwd", 1'b1, run_f)
        `CHK("jog_ramp_sel", 2'h3, ramp)
        wb(1'b0, 8'h64, 32'h0);
        `CHK("status", 32'h00190032, rd)
        wb(1'b1, 8'h5c, 32'h00058210);
        pins(5'b10001, 5'b00000);
        `CHK("jog_stop", 1'b0, run_f)
        wb(1'b1, 8'h58, 32'h3);
        pins(5'b10000, 5'b00010);
        `CHK("jog_off_m3", 1'b0, jog)
        wb(1'b1, 8'h58, 32'h0);
        wb(1'b1, 8'h48, 32'h01f4);
        wb(1'b1, 8'h4c, 32'h1);
        pins(5'h00, 5'h00);
        `CHK("s_ramp_ref", 16'h01f4, rref)
    endtask
    task automatic t_remote_panel();
        wb(1'b1, 8'h54, 32'h1);
        pins(5'b00100, 5'h00);
        `CHK("remote_up", 1'b1, r_up)
        `CHK("voltage_src", 3'h6, src)
        @(posedge ref_clk);
        cur_en <= 1'b1;
        pins(5'b00011, 5'h00);
        `CHK("remote_down", 1'b1, r_dn)
        `CHK("remote_clear", 1'b1, r_clr)
        `CHK("current_src", 3'h2, src)
        wb(1'b1, 8'h54, 32'h0);
        mode <= 2'h1;
        wb(1'b1, 8'h60, 32'h1);
        pins(5'h00, 5'b00100);
        `CHK("panel_jog", 1'b1, jog)
        `CHK("panel_fwd", 1'b1, run_f)
        pins(5'h00, 5'h00);
        `CHK("panel_stop", 1'b0, run_f)
        wb(1'b1, 8'h58, 32'h4);
        pins(5'h00, 5'b10000);
        `CHK("unit_rev", 1'b1, run_r)
        @(posedge ref_clk);
        mode <= 2'h2;
        wb(1'b1, 8'h00, 32'h00000111);
        wb(1'b0, 8'h00, 32'h0);
        `CHK("preset_locked", 32'h00000258, rd)
    endtask
    task automatic results();
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_presets();
        t_jog();
        t_remote_panel();
        results();
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        mismatches++;
        results();
    end
endmodule
